// *** src/fbc_defs.svh ***
// Constants of the flash boot command handler.
`ifndef FBC_DEFS_SVH
`define FBC_DEFS_SVH

`define FBC_CMD_PROG 8'h50
`define FBC_CMD_PROG_SEL 8'h40
`define FBC_CMD_ERASE_SEL 8'h48
`define FBC_CMD_ERASE_BLK 8'h58
`define FBC_RSP_ACK 8'h06
`define FBC_RSP_ERR 8'hD0
`define FBC_ERR_SUM 8'h11
`define FBC_ERR_PROG 8'h53
`define FBC_ERR_ERASE 8'h54
`define FBC_END_ADDR 32'hFFFF_FFFF
`define FBC_END_BLOCK 8'hFF
`define FBC_ADDR_LAST 7'h03
`define FBC_DATA_LAST 7'h7F
`define FBC_UNIT_BYTES 128

`endif

// *** src/fbc_pkg.sv ***
// Types of the flash boot command handler.
package fbc_pkg;

	typedef enum logic [3:0] {
		ST_SELECT,
		ST_PWAIT,
		ST_PADDR,
		ST_PDATA,
		ST_PSUM,
		ST_PROG,
		ST_EWAIT,
		ST_EBLK,
		ST_ESUM,
		ST_ERASE,
		ST_RSP,
		ST_HALT
	} fbc_state_t;

	typedef enum logic [1:0] {
		TX_IDLE,
		TX_B0,
		TX_B1
	} fbc_tx_state_t;

endpackage

// *** src/fbc_rsp_if.sv ***
// Response request path between the command handler and its transmitter.
`timescale 1ns/1ps

interface fbc_rsp_if;
	logic send;
	logic [7:0] byte0;
	logic [7:0] byte1;
	logic two;
	logic busy;

	modport ctrl (output send, output byte0, output byte1, output two,
		input busy);
	modport tx (input send, input byte0, input byte1, input two,
		output busy);
endinterface

// *** src/fbc_rsp_tx.sv ***
// Sends a one or two byte response onto the outgoing byte stream.
`timescale 1ns/1ps

module fbc_rsp_tx (
	input wire logic clk_i,
	input wire logic rst_n_i,
	fbc_rsp_if.tx rsp,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i
);
	fbc_pkg::fbc_tx_state_t state_q, state_d;
	logic [7:0] data_q, data_d;
	logic [7:0] second_q, second_d;
	logic two_q, two_d;

	assign tx_valid_o = (state_q != fbc_pkg::TX_IDLE);
	assign tx_data_o = data_q;
	assign rsp.busy = (state_q != fbc_pkg::TX_IDLE);

	always_comb begin
		state_d = state_q;
		data_d = data_q;
		second_d = second_q;
		two_d = two_q;
		case (state_q)
			fbc_pkg::TX_IDLE: begin
				if (rsp.send) begin
					data_d = rsp.byte0;
					second_d = rsp.byte1;
					two_d = rsp.two;
					state_d = fbc_pkg::TX_B0;
				end
			end
			fbc_pkg::TX_B0: begin
				if (tx_ready_i) begin
					if (two_q) begin
						data_d = second_q;
						state_d = fbc_pkg::TX_B1;
					end else begin
						state_d = fbc_pkg::TX_IDLE;
					end
				end
			end
			default: begin
				if (tx_ready_i) begin
					state_d = fbc_pkg::TX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= fbc_pkg::TX_IDLE;
			data_q <= 8'h00;
			second_q <= 8'h00;
			two_q <= 1'b0;
		end else begin
			state_q <= state_d;
			data_q <= data_d;
			second_q <= second_d;
			two_q <= two_d;
		end
	end
endmodule

// *** src/fbc_top.sv ***
// Boot-mode flash command handler: frame parsing, checks and responses.
`timescale 1ns/1ps
`include "fbc_defs.svh"

module fbc_top (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_data_i,
	output logic rx_ready_o,
	output logic tx_valid_o,
	output logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	output logic pgm_start_o,
	output logic [31:0] pgm_addr_o,
	input wire logic [6:0] pgm_rd_idx_i,
	output logic [7:0] pgm_rd_data_o,
	output logic ers_start_o,
	output logic [7:0] ers_block_o,
	input wire logic flash_done_i,
	input wire logic flash_fail_i,
	output logic halted_o
);
	fbc_pkg::fbc_state_t state_q, state_d;
	fbc_pkg::fbc_state_t ret_q, ret_d;
	logic [7:0] sum_q, sum_d;
	logic [6:0] cnt_q, cnt_d;
	logic [31:0] addr_q, addr_d;
	logic [7:0] blk_q, blk_d;
	logic end_q, end_d;
	logic pgm_q, pgm_d;
	logic ers_q, ers_d;
	logic [7:0] rd_q;
	logic [7:0] unit_mem [`FBC_UNIT_BYTES];
	logic mem_we;
	logic fire;
	logic sum_ok;
	logic do_ack;
	logic do_err;
	logic [7:0] err_code;
	fbc_pkg::fbc_state_t next_ret;

	fbc_rsp_if rsp ();

	fbc_rsp_tx u_tx (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.rsp(rsp.tx),
		.tx_valid_o(tx_valid_o),
		.tx_data_o(tx_data_o),
		.tx_ready_i(tx_ready_i)
	);

	// Bytes are only taken in the select state and in states that parse a frame.
	always_comb begin
		case (state_q)
			fbc_pkg::ST_SELECT, fbc_pkg::ST_PWAIT, fbc_pkg::ST_PADDR,
			fbc_pkg::ST_PDATA, fbc_pkg::ST_PSUM, fbc_pkg::ST_EWAIT,
			fbc_pkg::ST_EBLK, fbc_pkg::ST_ESUM: rx_ready_o = 1'b1;
			default: rx_ready_o = 1'b0;
		endcase
	end

	assign fire = rx_valid_i && rx_ready_o;
	assign sum_ok = ((sum_q + rx_data_i) == 8'h00);
	assign mem_we = fire && (state_q == fbc_pkg::ST_PDATA);

	always_comb begin
		state_d = state_q;
		ret_d = ret_q;
		sum_d = sum_q;
		cnt_d = cnt_q;
		addr_d = addr_q;
		blk_d = blk_q;
		end_d = end_q;
		pgm_d = 1'b0;
		ers_d = 1'b0;
		do_ack = 1'b0;
		do_err = 1'b0;
		err_code = `FBC_ERR_SUM;
		next_ret = state_q;
		if (fire) begin
			sum_d = sum_q + rx_data_i;
		end
		case (state_q)
			fbc_pkg::ST_SELECT: begin
				if (fire && rx_data_i == `FBC_CMD_PROG_SEL) begin
					do_ack = 1'b1;
					next_ret = fbc_pkg::ST_PWAIT;
				end else if (fire && rx_data_i == `FBC_CMD_ERASE_SEL) begin
					do_ack = 1'b1;
					next_ret = fbc_pkg::ST_EWAIT;
				end
			end
			fbc_pkg::ST_PWAIT: begin
				if (fire && rx_data_i == `FBC_CMD_PROG) begin
					sum_d = rx_data_i;
					cnt_d = 7'h00;
					state_d = fbc_pkg::ST_PADDR;
				end
			end
			fbc_pkg::ST_PADDR: begin
				if (fire) begin
					addr_d = {addr_q[23:0], rx_data_i};
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == `FBC_ADDR_LAST) begin
						cnt_d = 7'h00;
						end_d = ({addr_q[23:0], rx_data_i} == `FBC_END_ADDR);
						if ({addr_q[23:0], rx_data_i} == `FBC_END_ADDR) begin
							state_d = fbc_pkg::ST_PSUM;
						end else begin
							state_d = fbc_pkg::ST_PDATA;
						end
					end
				end
			end
			fbc_pkg::ST_PDATA: begin
				if (fire) begin
					cnt_d = cnt_q + 7'h01;
					if (cnt_q == `FBC_DATA_LAST) begin
						state_d = fbc_pkg::ST_PSUM;
					end
				end
			end
			fbc_pkg::ST_PSUM: begin
				// Nothing is programmed before the sum passes.
				if (fire) begin
					if (!sum_ok) begin
						do_err = 1'b1;
						next_ret = fbc_pkg::ST_PWAIT;
					end else if (end_q) begin
						do_ack = 1'b1;
						next_ret = fbc_pkg::ST_SELECT;
					end else begin
						pgm_d = 1'b1;
						state_d = fbc_pkg::ST_PROG;
					end
				end
			end
			fbc_pkg::ST_PROG: begin
				if (flash_done_i) begin
					if (flash_fail_i) begin
						// A flash fault ends all programming.
						do_err = 1'b1;
						err_code = `FBC_ERR_PROG;
						next_ret = fbc_pkg::ST_HALT;
					end else begin
						do_ack = 1'b1;
						next_ret = fbc_pkg::ST_PWAIT;
					end
				end
			end
			fbc_pkg::ST_EWAIT: begin
				if (fire && rx_data_i == `FBC_CMD_ERASE_BLK) begin
					sum_d = rx_data_i;
					state_d = fbc_pkg::ST_EBLK;
				end
			end
			fbc_pkg::ST_EBLK: begin
				if (fire) begin
					blk_d = rx_data_i;
					state_d = fbc_pkg::ST_ESUM;
				end
			end
			fbc_pkg::ST_ESUM: begin
				if (fire) begin
					if (!sum_ok) begin
						do_err = 1'b1;
						next_ret = fbc_pkg::ST_EWAIT;
					end else if (blk_q == `FBC_END_BLOCK) begin
						do_ack = 1'b1;
						next_ret = fbc_pkg::ST_SELECT;
					end else begin
						ers_d = 1'b1;
						state_d = fbc_pkg::ST_ERASE;
					end
				end
			end
			fbc_pkg::ST_ERASE: begin
				if (flash_done_i) begin
					do_ack = !flash_fail_i;
					do_err = flash_fail_i;
					err_code = `FBC_ERR_ERASE;
					next_ret = fbc_pkg::ST_EWAIT;
				end
			end
			fbc_pkg::ST_RSP: begin
				if (!rsp.busy) begin
					state_d = ret_q;
				end
			end
			default: begin
				state_d = fbc_pkg::ST_HALT;
			end
		endcase
		if (do_ack || do_err) begin
			ret_d = next_ret;
			state_d = fbc_pkg::ST_RSP;
		end
	end

	// Error replies carry a code byte.
	// Code chosen by the failing step.
	always_comb begin
		rsp.send = do_ack || do_err;
		rsp.two = do_err;
		rsp.byte0 = do_err ? `FBC_RSP_ERR : `FBC_RSP_ACK;
		rsp.byte1 = err_code;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= fbc_pkg::ST_SELECT;
			ret_q <= fbc_pkg::ST_SELECT;
			sum_q <= 8'h00;
			cnt_q <= 7'h00;
			addr_q <= 32'h0000_0000;
			blk_q <= 8'h00;
			end_q <= 1'b0;
			pgm_q <= 1'b0;
			ers_q <= 1'b0;
			rd_q <= 8'h00;
		end else begin
			state_q <= state_d;
			ret_q <= ret_d;
			sum_q <= sum_d;
			cnt_q <= cnt_d;
			addr_q <= addr_d;
			blk_q <= blk_d;
			end_q <= end_d;
			pgm_q <= pgm_d;
			ers_q <= ers_d;
			rd_q <= unit_mem[pgm_rd_idx_i];
		end
	end

	// The unit buffer has no reset; the flash side reads it only after a
	// full frame has been stored.
	always_ff @(posedge clk_i) begin
		if (mem_we) begin
			unit_mem[cnt_q] <= rx_data_i;
		end
	end

	assign pgm_start_o = pgm_q;
	assign pgm_addr_o = addr_q;
	assign pgm_rd_data_o = rd_q;
	assign ers_start_o = ers_q;
	assign ers_block_o = blk_q;
	assign halted_o = (state_q == fbc_pkg::ST_HALT);
endmodule

// *** tb/fbc_checker.sv ***
// Port assertions of the flash boot command handler.
`timescale 1ns/1ps
module fbc_checker (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic rx_ready_o,
	input wire logic tx_valid_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_ready_i,
	input wire logic pgm_start_o,
	input wire logic ers_start_o,
	input wire logic flash_done_i,
	input wire logic flash_fail_i,
	input wire logic halted_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_ack;
		flash_done_i && !flash_fail_i |=> tx_valid_o && tx_data_o == 8'h06;
	endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_err;
		flash_done_i && flash_fail_i |=> tx_valid_o && tx_data_o == 8'hD0;
	endproperty
	a_err: assert property (p_err) else $error("no error byte");
	property p_code;
		tx_valid_o && tx_ready_i && tx_data_o == 8'hD0 |=>
			tx_valid_o && tx_data_o inside {8'h11, 8'h53, 8'h54};
	endproperty
	a_code: assert property (p_code) else $error("bad code");
	property p_halt;
		tx_valid_o && tx_ready_i && tx_data_o == 8'h53 |-> ##[1:2] halted_o;
	endproperty
	a_halt: assert property (p_halt) else $error("no halt");
	property p_stay;
		halted_o |=> halted_o && !rx_ready_o && !pgm_start_o;
	endproperty
	a_stay: assert property (p_stay) else $error("left halt");
	property p_stand;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
	endproperty
	a_stand: assert property (p_stand) else $error("tx dropped");
	property p_busy;
		tx_valid_o |-> !rx_ready_o;
	endproperty
	a_busy: assert property (p_busy) else $error("rx while tx");
	property p_pgm;
		pgm_start_o |=> !pgm_start_o && !rx_ready_o;
	endproperty
	a_pgm: assert property (p_pgm) else $error("bad pgm start");
	property p_ers;
		ers_start_o |=> !ers_start_o && !rx_ready_o;
	endproperty
	a_ers: assert property (p_ers) else $error("bad ers start");
endmodule

bind fbc_top fbc_checker i_fbc_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
	.tx_ready_i(tx_ready_i), .pgm_start_o(pgm_start_o),
	.ers_start_o(ers_start_o), .flash_done_i(flash_done_i),
	.flash_fail_i(flash_fail_i), .halted_o(halted_o));

// *** tb/fbc_flash_model.sv ***
// Flash array model that reads the unit buffer and reports completion.
`timescale 1ns/1ps
module fbc_flash_model (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic start_i,
	input wire logic fail_i,
	input wire logic [7:0] rd_data_i,
	output logic [6:0] rd_idx_o,
	output logic done_o,
	output logic fail_o,
	output logic [7:0] rd_sum_o
);
	logic busy_q;
	logic [7:0] cnt_q;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			rd_idx_o <= 7'h00;
			done_o <= 1'b0;
			fail_o <= 1'b0;
			rd_sum_o <= 8'h00;
		end else begin
			done_o <= 1'b0;
			fail_o <= 1'b0;
			if (start_i) begin
				busy_q <= 1'b1;
				cnt_q <= 8'h00;
				rd_sum_o <= 8'h00;
			end else if (busy_q) begin
				cnt_q <= cnt_q + 8'h01;
				rd_idx_o <= cnt_q[6:0];
				if (cnt_q >= 8'h02 && cnt_q <= 8'h81)
					rd_sum_o <= rd_sum_o + rd_data_i;
				if (cnt_q == 8'h82) begin
					busy_q <= 1'b0;
					done_o <= 1'b1;
					fail_o <= fail_i;
				end
			end
		end
	end
endmodule

// *** tb/fbc_top_tb.sv ***
// Self-checking bench of the flash boot command handler.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module fbc_top_tb;
	logic clk_i = 0, rst_n_i = 0, rx_valid_i = 0, tx_ready_i = 0, fail = 0;
	logic [7:0] rx_data_i = 8'h00, rs = 8'h1A, rd_sum, ds;
	logic [7:0] rv = 8'h1A, db, exp_b;
	logic rx_ready_o, tx_valid_o, pgm_start_o, ers_start_o, halted_o;
	logic done, ffail;
	logic [7:0] tx_data_o, pgm_rd_data_o, ers_block_o;
	logic [31:0] pgm_addr_o;
	logic [6:0] idx;
	logic [7:0] exp_q[$], q[$];
	int n_errors = 0, cmp_count = 0, n_pgm = 0, n_ers = 0;
	fbc_top i_fbc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_ready_o(rx_ready_o),
		.tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
		.pgm_start_o(pgm_start_o), .pgm_addr_o(pgm_addr_o),
		.pgm_rd_idx_i(idx), .pgm_rd_data_o(pgm_rd_data_o),
		.ers_start_o(ers_start_o), .ers_block_o(ers_block_o),
		.flash_done_i(done), .flash_fail_i(ffail), .halted_o(halted_o));
	fbc_flash_model i_fbc_flash_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.start_i(pgm_start_o | ers_start_o), .fail_i(fail),
		.rd_data_i(pgm_rd_data_o), .rd_idx_o(idx), .done_o(done),
		.fail_o(ffail), .rd_sum_o(rd_sum));
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	initial forever #5 clk_i = ~clk_i;
	// Random stalls on the response stream.
	always @(posedge clk_i) begin
		#1;
		rs = lfsr(rs);
		tx_ready_i = rs[0] | rs[2];
	end
	// Outputs are looked at mid-cycle, where they have settled.
	always @(negedge clk_i) begin
		if (pgm_start_o)
			n_pgm++;
		if (ers_start_o)
			n_ers++;
		if (tx_valid_o && tx_ready_i) begin
			// A byte nobody asked for meets 00, which is never a reply.
			exp_b = 8'h00;
			if (exp_q.size() != 0)
				exp_b = exp_q.pop_front();
			`CHK("tx byte", exp_b, tx_data_o)
		end
	end
	task automatic send(input logic [7:0] b);
		rx_valid_i = 1'b1;
		rx_data_i = b;
		do @(negedge clk_i); while (rx_ready_o !== 1'b1);
		@(posedge clk_i);
		#1;
	endtask
	// Frame bytes plus a sum that zeroes the total, skewed by adj.
	task automatic frame(input logic [7:0] f[$], input logic [7:0] adj);
		logic [7:0] s;
		s = 8'h00;
		foreach (f[i]) begin
			s -= f[i];
			send(f[i]);
		end
		send(s + adj);
		settle();
	endtask
	// Idles the host and waits until every noted reply has been seen.
	task automatic settle();
		rx_valid_i = 1'b0;
		for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk_i);
		`CHK("replies left", 0, exp_q.size())
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#300_000;
		n_errors++;
		complete_run();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		q = {8'h50, 8'h00, 8'h00, 8'h00, 8'h80};
		ds = 8'h00;
		for (int i = 0; i < 128; i++) begin
			rv = lfsr(rv);
			db = (i < 100) ? rv : 8'hFF;
			q.push_back(db);
			ds += db;
		end
		// Selection codes are single bytes with no checksum.
		exp_q = {8'h06};
		send(8'h40);
		settle();
		exp_q = {8'h06};
		// unit programmed from a full frame
		frame(q, 8'h00);
		`CHK("addr", 32'h0000_0080, pgm_addr_o)
		`CHK("data sum", ds, rd_sum)
		exp_q = {8'hD0, 8'h11};
		frame(q, 8'h01);
		`CHK("units", 1, n_pgm)
		exp_q = {8'h06};
		frame({8'h50, 8'hFF, 8'hFF, 8'hFF, 8'hFF}, 8'h00);
		`CHK("units", 1, n_pgm)
		$display("program tests done");
		exp_q = {8'h06};
		send(8'h48);
		settle();
		exp_q = {8'h06};
		frame({8'h58, 8'h03}, 8'h00);
		`CHK("block", 8'h03, ers_block_o)
		`CHK("erases", 1, n_ers)
		// An erase fault is reported but the session goes on.
		exp_q = {8'hD0, 8'h54};
		fail = 1'b1;
		frame({8'h58, 8'h07}, 8'h00);
		fail = 1'b0;
		exp_q = {8'hD0, 8'h11};
		frame({8'h58, 8'h07}, 8'h01);
		`CHK("erases", 2, n_ers)
		exp_q = {8'h06};
		frame({8'h58, 8'hFF}, 8'h00);
		`CHK("erases", 2, n_ers)
		$display("erase tests done");
		// A programming fault stops the handler until a reset.
		exp_q = {8'h06};
		send(8'h40);
		settle();
		exp_q = {8'hD0, 8'h53};
		fail = 1'b1;
		frame(q, 8'h00);
		`CHK("halted", 1'b1, halted_o)
		`CHK("refused", 1'b0, rx_ready_o)
		`CHK("units", 2, n_pgm)
		$display("fault test done");
		// Only a reset leaves the halted state.
		fail = 1'b0;
		rst_n_i = 1'b0;
		repeat (2) @(posedge clk_i);
		#1 rst_n_i = 1'b1;
		`CHK("halt left", 1'b0, halted_o)
		`CHK("ready again", 1'b1, rx_ready_o)
		exp_q = {8'h06};
		send(8'h48);
		settle();
		exp_q = {8'h06};
		frame({8'h58, 8'hFF}, 8'h00);
		`CHK("erases", 2, n_ers)
		$display("reset test done");
		complete_run();
	end
endmodule
